// ---- rtl/intd_params.svh ----
// Field positions and encodings of the interrupt transfer descriptor.
`ifndef INTD_PARAMS_SVH
`define INTD_PARAMS_SVH

// Upper descriptor half: third word above second word.
`define HI_ACTIVE 63
`define HI_HALT 62
`define HI_TOGGLE 57
`define HI_CERR_MSB 56
`define HI_CERR_LSB 55
`define HI_DONE_MSB 46
`define HI_DONE_LSB 32
`define HI_ADDR_MSB 23
`define HI_ADDR_LSB 8
`define HI_RATE_MSB 7
`define HI_RATE_LSB 3

// Lower descriptor half: first word above zeroth word.
`define LO_SPLIT 46
`define LO_TOKEN_MSB 43
`define LO_TOKEN_LSB 42
`define LO_FUNC_MSB 41
`define LO_FUNC_LSB 35
`define LO_EP_MSB 34
`define LO_EP_LSB 32
`define LO_EP_BIT0 31
`define LO_MULT_MSB 30
`define LO_MULT_LSB 29
`define LO_MAXP_MSB 28
`define LO_MAXP_LSB 18
`define LO_SIZE_MSB 17
`define LO_SIZE_LSB 3
`define LO_VALID 0

// Token encodings and per-micro-frame status bits.
`define TOKEN_OUT 2'h0
`define TOKEN_IN 2'h1
`define STAT_XERR 0
`define STAT_BABBLE 1
`define STAT_UNDERRUN 2

// Reset values.
`define RST_CERR 2'h0
`define RST_MASK 8'h00

`endif

// ---- rtl/intd_pkg.sv ----
// Types shared by the interrupt descriptor engine.
package intd_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_NEXT, ST_TOKEN} xfer_state_e;
    typedef logic [2:0] uf_status_t;
    typedef logic [14:0] byte_count_t;
endpackage : intd_pkg

// ---- rtl/poll_if.sv ----
// Carrier between the descriptor engine and its micro-frame scheduler.
`timescale 1ns/100ps
`default_nettype none
interface poll_if;
    logic [4:0] frame_num;
    logic [2:0] uframe_num;
    logic [4:0] rate;
    logic [7:0] mask;
    logic hit;
    modport sched (input frame_num, input uframe_num, input rate, input mask, output hit);
    modport ctrl (output frame_num, output uframe_num, output rate, output mask, input hit);
endinterface : poll_if
`default_nettype wire

// ---- rtl/poll_sched.sv ----
// Decides whether the current micro-frame polls the interrupt endpoint.
`timescale 1ns/100ps
`default_nettype none
module poll_sched (
    input wire logic sys_clk,
    input wire logic resetn,
    poll_if.sched pif
);
    logic [4:0] smear;
    wire frame_match;
    wire uframe_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // period from rate
    // The highest set rate bit fixes the period; the whole rate value, that bit included, gives the phase.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_smear
            assign smear[gi] = |pif.rate[4:gi];
        end
    endgenerate

    assign frame_match = ((pif.frame_num & smear) == pif.rate);
    assign uframe_enabled = pif.mask[pif.uframe_num];
    assign pif.hit = frame_match && uframe_enabled;

    a_hit_needs_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
        pif.hit |-> pif.mask[pif.uframe_num]) else $error("poll hit without mask bit");
    a_fast_rate_any: assert property (@(posedge sys_clk) disable iff (!resetn)
        (pif.rate == 5'h00 && pif.mask[pif.uframe_num]) |-> pif.hit)
        else $error("fast rate missed an enabled micro-frame");
endmodule : poll_sched
`default_nettype wire

// ---- rtl/intd_engine.sv ----
// Executes one high-speed interrupt IN or OUT transfer descriptor.
`timescale 1ns/100ps
`default_nettype none
`include "intd_params.svh"
module intd_engine (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic desc_load,
    input wire logic [63:0] desc_lo,
    input wire logic [63:0] desc_hi,
    input wire logic [7:0] desc_mask,
    input wire logic uframe_tick,
    input wire logic [4:0] frame_num,
    input wire logic [2:0] uframe_num,
    input wire logic txn_done,
    input wire logic [10:0] txn_bytes,
    input wire logic txn_err,
    input wire logic txn_babble,
    input wire logic txn_underrun,
    input wire logic txn_stall,
    output logic tok_req_q,
    output logic tok_in_q,
    output logic tok_split_q,
    output logic [6:0] tok_func_q,
    output logic [3:0] tok_ep_q,
    output logic [10:0] tok_len_q,
    output logic [15:0] tok_buf_addr_q,
    output logic busy_q,
    output logic valid_q,
    output logic active_q,
    output logic halt_q,
    output logic toggle_q,
    output logic [1:0] cerr_q,
    output intd_pkg::byte_count_t bytes_done_q,
    output logic [7:0] mask_q,
    output intd_pkg::uf_status_t [7:0] status_q,
    output logic wb_q
);
    import intd_pkg::*;

    xfer_state_e state_q;
    byte_count_t size_q;
    logic [10:0] maxp_q;
    logic [1:0] mult_q;
    logic [1:0] pkt_cnt_q;
    logic [15:0] start_q;
    logic [4:0] rate_q;
    logic [2:0] cur_uf_q;

    poll_if pif ();

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor decode.
    wire load_valid = desc_lo[`LO_VALID];
    wire load_active = desc_hi[`HI_ACTIVE];
    wire load_halt = desc_hi[`HI_HALT];
    wire load_runs = load_valid && load_active && !load_halt;
    wire load_in = (desc_lo[`LO_TOKEN_MSB:`LO_TOKEN_LSB] == `TOKEN_IN);
    wire [3:0] load_ep = {desc_lo[`LO_EP_MSB:`LO_EP_LSB], desc_lo[`LO_EP_BIT0]};

    ////////////////////////////////////////////////////////////////////////////
    // Packet sizing and outcome decode.
    wire [14:0] remaining = size_q - bytes_done_q;
    wire [10:0] next_len = (remaining > {4'h0, maxp_q}) ? maxp_q : remaining[10:0];
    wire [15:0] next_addr = start_q + {4'h0, bytes_done_q[14:3]};
    wire [14:0] sum_bytes = bytes_done_q + {4'h0, txn_bytes};
    wire resp = (state_q == ST_TOKEN) && txn_done;
    // babble only on IN, underrun only on OUT
    wire got_babble = txn_babble && tok_in_q;
    wire got_underrun = txn_underrun && !tok_in_q;
    wire got_xerr = txn_err || got_underrun;
    // Stalls and babble halt at once; plain errors halt once the counter runs out.
    wire cerr_out = (cerr_q == 2'h1);
    wire fatal = got_babble || txn_stall || (got_xerr && cerr_out);
    wire good = !got_babble && !txn_stall && !got_xerr;
    // stop at transfer size or on a short packet
    wire complete = good && ((sum_bytes >= size_q) || (txn_bytes < tok_len_q));
    wire more_pkts = (pkt_cnt_q < mult_q);

    assign pif.frame_num = frame_num;
    assign pif.uframe_num = uframe_num;
    assign pif.rate = rate_q;
    assign pif.mask = mask_q;

    poll_sched u_sched (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pif(pif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            pkt_cnt_q <= 2'h0;
            cur_uf_q <= 3'h0;
            tok_req_q <= 1'b0;
            tok_len_q <= 11'h000;
            tok_buf_addr_q <= 16'h0000;
            wb_q <= 1'b0;
        end else begin
            wb_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (desc_load && load_runs) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (uframe_tick && pif.hit) begin
                        cur_uf_q <= uframe_num;
                        pkt_cnt_q <= 2'h0;
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    tok_req_q <= 1'b1;
                    tok_len_q <= next_len;
                    tok_buf_addr_q <= next_addr;
                    pkt_cnt_q <= pkt_cnt_q + 2'h1;
                    state_q <= ST_TOKEN;
                end
                ST_TOKEN: begin
                    if (txn_done) begin
                        tok_req_q <= 1'b0;
                        wb_q <= 1'b1;
                        if (fatal || complete) begin
                            state_q <= ST_IDLE;
                        end else if (good && more_pkts) begin
                            state_q <= ST_NEXT;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor fields that software loads and the sequencer only reads.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            size_q <= 15'h0000;
            maxp_q <= 11'h000;
            mult_q <= 2'h0;
            start_q <= 16'h0000;
            rate_q <= 5'h00;
            tok_in_q <= 1'b0;
            tok_split_q <= 1'b0;
            tok_func_q <= 7'h00;
            tok_ep_q <= 4'h0;
        end else if (desc_load && state_q == ST_IDLE) begin
            size_q <= desc_lo[`LO_SIZE_MSB:`LO_SIZE_LSB];
            maxp_q <= desc_lo[`LO_MAXP_MSB:`LO_MAXP_LSB];
            mult_q <= desc_lo[`LO_MULT_MSB:`LO_MULT_LSB];
            start_q <= desc_hi[`HI_ADDR_MSB:`HI_ADDR_LSB];
            rate_q <= desc_hi[`HI_RATE_MSB:`HI_RATE_LSB];
            tok_in_q <= load_in;
            tok_split_q <= desc_lo[`LO_SPLIT];
            tok_func_q <= desc_lo[`LO_FUNC_MSB:`LO_FUNC_LSB];
            tok_ep_q <= load_ep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write-back fields, shared between software load and hardware update.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            active_q <= 1'b0;
            halt_q <= 1'b0;
            toggle_q <= 1'b0;
            cerr_q <= `RST_CERR;
            bytes_done_q <= 15'h0000;
            mask_q <= `RST_MASK;
            status_q <= '0;
        end else if (desc_load && state_q == ST_IDLE) begin
            valid_q <= load_valid;
            active_q <= load_active;
            halt_q <= load_halt;
            toggle_q <= desc_hi[`HI_TOGGLE];
            cerr_q <= desc_hi[`HI_CERR_MSB:`HI_CERR_LSB];
            bytes_done_q <= 15'h0000;
            mask_q <= desc_mask;
            status_q <= '0;
        end else if (resp) begin
            status_q[cur_uf_q][`STAT_XERR] <= txn_err;
            status_q[cur_uf_q][`STAT_BABBLE] <= got_babble;
            status_q[cur_uf_q][`STAT_UNDERRUN] <= got_underrun;
            if (good) begin
                toggle_q <= !toggle_q;
                bytes_done_q <= sum_bytes;
                if (!more_pkts || complete) begin
                    mask_q[cur_uf_q] <= 1'b0;
                end
            end
            if (got_xerr && cerr_q != 2'h0) begin
                cerr_q <= cerr_q - 2'h1;
            end
            if (fatal) begin
                halt_q <= 1'b1;
            end
            // valid cleared when done or fatal
            if (fatal || complete) begin
                valid_q <= 1'b0;
                active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != ST_IDLE) || (desc_load && load_runs);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_halt_on_fatal: assert property (resp && fatal |=> halt_q && !valid_q)
        else $error("fatal response did not halt");
    a_toggle_flips: assert property (resp && good |=> toggle_q != $past(toggle_q))
        else $error("toggle not advanced after good packet");
    a_bytes_summed: assert property (
        resp && good |=> bytes_done_q == $past(bytes_done_q) + {4'h0, $past(txn_bytes)})
        else $error("transferred count wrong");
    a_no_traffic_idle: assert property (state_q == ST_IDLE |-> !tok_req_q)
        else $error("token request while idle");
    a_len_within_max: assert property ($rose(tok_req_q) |-> tok_len_q <= maxp_q)
        else $error("packet longer than max packet size");
    a_len_within_size: assert property (
        $rose(tok_req_q) |-> {4'h0, tok_len_q} <= size_q - bytes_done_q)
        else $error("packet passes transfer size");
    a_valid_done: assert property (
        resp && complete |=> !valid_q && !active_q && state_q == ST_IDLE)
        else $error("valid not cleared on completion");
    a_pkts_per_uf: assert property (tok_req_q |-> pkt_cnt_q <= mult_q)
        else $error("too many packets in a micro-frame");
    a_token_dir: assert property (
        desc_load && state_q == ST_IDLE |=>
        tok_in_q == ($past(desc_lo[`LO_TOKEN_LSB]) && !$past(desc_lo[`LO_TOKEN_MSB])))
        else $error("token direction not decoded");
    a_mask_retired: assert property (
        resp && good && !more_pkts |=> !mask_q[cur_uf_q])
        else $error("micro-frame mask bit left set after its last packet");
    a_babble_status: assert property (
        resp |=> status_q[cur_uf_q][`STAT_BABBLE] == ($past(txn_babble) && tok_in_q))
        else $error("babble status bit wrong");
    a_no_poll_miss: assert property (
        state_q == ST_WAIT && uframe_tick && !pif.hit |=> state_q == ST_WAIT)
        else $error("engine left waiting on a masked micro-frame");
endmodule : intd_engine
`default_nettype wire

// ---- rtl/intd_engine_fix.sv ----
// Spare source slot; it holds no logic of its own.

// ---- bench/func_endpoint_model.sv ----
// Behavioural interrupt endpoint that answers the engine's token requests.
`timescale 1ns/100ps
`default_nettype none
module func_endpoint_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tok_req,
    input wire logic [10:0] tok_len,
    input wire logic [3:0] delay,
    input wire logic [10:0] short_by,
    input wire logic [3:0] fault,
    output logic txn_done,
    output logic [10:0] txn_bytes,
    output logic txn_err,
    output logic txn_babble,
    output logic txn_underrun,
    output logic txn_stall
);
    logic [3:0] wait_q;
    logic [10:0] last_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txn_done <= 1'b0;
            wait_q <= 4'h0;
            last_q <= 11'h000;
        end else if (txn_done) begin
            txn_done <= 1'b0;
            wait_q <= 4'h0;
        end else if (tok_req && wait_q >= delay) begin
            txn_done <= 1'b1;
            last_q <= tok_len - short_by;
        end else if (tok_req) begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // Outside a response the byte count means nothing, so it carries garbage.
    assign txn_bytes = txn_done ? last_q : ~last_q;
    assign {txn_stall, txn_underrun, txn_babble, txn_err} = txn_done ? fault : 4'h0;
endmodule : func_endpoint_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the interrupt transfer descriptor engine.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import intd_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic desc_load = 1'b0;
    logic [63:0] desc_lo = 64'h0;
    logic [63:0] desc_hi = 64'h0;
    logic [7:0] desc_mask = 8'h00;
    logic uframe_tick = 1'b0;
    logic [4:0] frame_num = 5'h00;
    logic [2:0] uframe_num = 3'h0;
    logic [3:0] delay = 4'h1;
    logic [10:0] short_by = 11'h000;
    logic [3:0] fault = 4'h0;
    logic txn_done, txn_err, txn_babble, txn_underrun, txn_stall, tok_req_q, tok_in_q;
    logic tok_split_q, busy_q, valid_q, active_q, halt_q, toggle_q, wb_q;
    logic [10:0] txn_bytes, tok_len_q;
    logic [6:0] tok_func_q;
    logic [3:0] tok_ep_q;
    logic [15:0] tok_buf_addr_q;
    logic [1:0] cerr_q;
    logic [7:0] mask_q;
    byte_count_t bytes_done_q;
    uf_status_t [7:0] status_q;
    integer miscompares = 0;
    integer checked = 0;

    intd_engine DUT (.sys_clk, .resetn, .desc_load, .desc_lo, .desc_hi, .desc_mask,
        .uframe_tick, .frame_num, .uframe_num, .txn_done, .txn_bytes, .txn_err,
        .txn_babble, .txn_underrun, .txn_stall, .tok_req_q, .tok_in_q, .tok_split_q,
        .tok_func_q, .tok_ep_q, .tok_len_q, .tok_buf_addr_q, .busy_q, .valid_q,
        .active_q, .halt_q, .toggle_q, .cerr_q, .bytes_done_q, .mask_q, .status_q, .wb_q);
    func_endpoint_model ep (.sys_clk, .resetn, .tok_req(tok_req_q), .tok_len(tok_len_q),
        .delay, .short_by, .fault, .txn_done, .txn_bytes, .txn_err, .txn_babble,
        .txn_underrun, .txn_stall);

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic give_up();
        miscompares = miscompares + 1;
        end_of_test();
    endtask : give_up

    // endpoint type is always the interrupt encoding.
    function automatic logic [63:0] mk_lo(logic tok, logic [6:0] fa, logic [3:0] e,
        logic [1:0] mult, logic [10:0] maxp, logic [14:0] size, logic split, logic vld);
        return {17'h0, split, 2'h3, 1'b0, tok, fa, e[3:1], e[0], mult, maxp, size, 2'h0, vld};
    endfunction : mk_lo

    // active is given apart from valid; address is already an internal one.
    function automatic logic [63:0] mk_hi(logic act, logic hlt, logic tog, logic [1:0] ce,
        logic [15:0] addr, logic [4:0] rate);
        return {act, hlt, 4'h0, tog, ce, 8'h0, 15'h0, 8'h0, addr, rate, 3'h0};
    endfunction : mk_hi

    task automatic load(input logic [63:0] lo, input logic [63:0] hi, input logic [7:0] m);
        @(negedge sys_clk);
        desc_lo = lo;
        desc_hi = hi;
        desc_mask = m;
        desc_load = 1'b1;
        @(negedge sys_clk);
        desc_load = 1'b0;
    endtask : load

    task automatic tick(input logic [4:0] fr, input logic [2:0] uf);
        @(negedge sys_clk);
        frame_num = fr;
        uframe_num = uf;
        uframe_tick = 1'b1;
        @(negedge sys_clk);
        uframe_tick = 1'b0;
    endtask : tick

    task automatic wait_req(input logic want);
        for (int i = 0; i < 6 && tok_req_q !== 1'b1; i++) @(negedge sys_clk);
        chk(tok_req_q, want);
        if (want && tok_req_q !== 1'b1) give_up();
    endtask : wait_req

    task automatic finish_pkt(input logic [10:0] len);
        chk(tok_len_q, len);
        for (int i = 0; i < 20 && tok_req_q === 1'b1; i++) @(negedge sys_clk);
        if (tok_req_q !== 1'b0) give_up();
        chk(wb_q, 1'b1);
        // Busy falls one cycle after the closing response, so settle before judging it.
        @(negedge sys_clk);
    endtask : finish_pkt

    task automatic rst();
        @(negedge sys_clk);
        resetn = 1'b0;
        fault = 4'h0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        chk({busy_q, valid_q, tok_req_q, halt_q}, 4'h0);
    endtask : rst

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_out();
        // processor address 0d18h maps to internal buffer address 0123h.
        load(mk_lo(1'b0, 7'h5a, 4'h9, 2'h1, 11'h008, 15'h0014, 1'b0, 1'b1),
            mk_hi(1'b1, 1'b0, 1'b0, 2'h3, 16'((32'h0d18 - 32'h0400) / 8), 5'h00), 8'hff);
        chk(busy_q, 1'b1);
        for (int p = 0; p < 3; p++) begin
            tick(5'h00, p[2:0]);
            wait_req(1'b1);
            chk(tok_in_q, 1'b0);
            chk(tok_split_q, 1'b0);
            chk(tok_func_q, 7'h5a);
            chk(tok_ep_q, 4'h9);
            chk(tok_buf_addr_q, 16'h0123 + p);
            finish_pkt(p == 2 ? 11'h004 : 11'h008);
            chk(bytes_done_q, p == 2 ? 15'h0014 : 15'h0008 * (p + 1));
            chk(toggle_q, (p + 1) % 2);
            chk(mask_q[p], 1'b0);
        end
        chk({valid_q, active_q, busy_q}, 3'h0);
    endtask : t_out

    task automatic t_in_mult();
        delay = 4'h3;
        load(mk_lo(1'b1, 7'h01, 4'h2, 2'h2, 11'h010, 15'h0064, 1'b1, 1'b1),
            mk_hi(1'b1, 1'b0, 1'b1, 2'h0, 16'h0040, 5'h00), 8'h04);
        tick(5'h00, 3'h1);
        wait_req(1'b0);
        tick(5'h00, 3'h2);
        for (int p = 0; p < 2; p++) begin
            wait_req(1'b1);
            chk({tok_in_q, tok_split_q}, 2'h3);
            finish_pkt(11'h010);
        end
        wait_req(1'b0);
        chk(bytes_done_q, 15'h0020);
        chk(busy_q, 1'b1);
        delay = 4'h1;
    endtask : t_in_mult

    task automatic t_fatal();
        for (int k = 0; k < 2; k++) begin
            rst();
            load(mk_lo(1'b1, 7'h11, 4'h1, 2'h1, 11'h040, 15'h0100, 1'b0, 1'b1),
                mk_hi(1'b1, 1'b0, 1'b0, 2'h3, 16'h0000, 5'h00), 8'h01);
            fault = k == 0 ? 4'h2 : 4'h8;
            tick(5'h00, 3'h0);
            wait_req(1'b1);
            finish_pkt(11'h040);
            chk({halt_q, valid_q, active_q, busy_q}, 4'h8);
            if (k == 0) chk(status_q[0][`STAT_BABBLE], 1'b1);
        end
    endtask : t_fatal

    task automatic t_err();
        load(mk_lo(1'b0, 7'h22, 4'h3, 2'h1, 11'h020, 15'h0100, 1'b0, 1'b1),
            mk_hi(1'b1, 1'b0, 1'b0, 2'h2, 16'h0000, 5'h00), 8'h01);
        for (int p = 0; p < 2; p++) begin
            fault = p == 0 ? 4'h1 : 4'h4;
            tick(5'h00, 3'h0);
            wait_req(1'b1);
            finish_pkt(11'h020);
            chk(cerr_q, 1 - p);
            chk(halt_q, p);
            chk(status_q[0][p == 0 ? `STAT_XERR : `STAT_UNDERRUN], 1'b1);
        end
    endtask : t_err

    task automatic t_skip();
        for (int k = 0; k < 3; k++) begin
            load(mk_lo(1'b0, 7'h01, 4'h1, 2'h1, 11'h008, 15'h0008, 1'b0, k != 0),
                mk_hi(k != 1, k == 2, 1'b0, 2'h0, 16'h0000, 5'h00), 8'hff);
            chk(busy_q, 1'b0);
            tick(5'h00, 3'h0);
            wait_req(1'b0);
        end
    endtask : t_skip

    task automatic t_rate();
        load(mk_lo(1'b1, 7'h33, 4'h4, 2'h1, 11'h008, 15'h0100, 1'b0, 1'b1),
            mk_hi(1'b1, 1'b0, 1'b0, 2'h0, 16'h0000, 5'h01), 8'h01);
        tick(5'h02, 3'h0);
        wait_req(1'b0);
        short_by = 11'h003;
        tick(5'h03, 3'h0);
        wait_req(1'b1);
        finish_pkt(11'h008);
        chk(bytes_done_q, 15'h0005);
        chk({valid_q, active_q, busy_q}, 3'h0);
        short_by = 11'h000;
    endtask : t_rate

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge sys_clk);
        resetn = 1'b1;
        chk({busy_q, tok_req_q, wb_q, mask_q}, 11'h000);
        t_out();
        rst();
        t_in_mult();
        t_fatal();
        rst();
        t_err();
        rst();
        t_skip();
        t_rate();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
